// ==== ffmt_pkg.sv ====
// Package of constants for the freefall/motion threshold comparison block.
package ffmt_pkg;

  // ----------------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------------
  localparam logic [7:0] ADDR_CFG        = 8'h15;
  localparam logic [7:0] ADDR_COMMON_THS = 8'h17;
  localparam logic [7:0] ADDR_COUNT      = 8'h18;
  localparam logic [7:0] ADDR_X_HIGH     = 8'h73;
  localparam logic [7:0] ADDR_X_LOW      = 8'h74;
  localparam logic [7:0] ADDR_Y_HIGH     = 8'h75;
  localparam logic [7:0] ADDR_Y_LOW      = 8'h76;
  localparam logic [7:0] ADDR_Z_HIGH     = 8'h77;
  localparam logic [7:0] ADDR_Z_LOW      = 8'h78;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h80;
  localparam logic [7:0] ADDR_IRQ_ENABLE = 8'h81;
  localparam logic [7:0] ADDR_IRQ_CLEAR  = 8'h82;
  localparam logic [7:0] ADDR_RESULT     = 8'h83;

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int CFG_OAE_BIT      = 6;
  localparam int CFG_ZEN_BIT      = 5;
  localparam int CFG_YEN_BIT      = 4;
  localparam int CFG_XEN_BIT      = 3;
  localparam int HIGH_SEL_BIT     = 7;
  localparam int THS_WIDTH        = 13;
  localparam int THS_SPLIT        = 6;
  localparam int LOW_FIELD_LSB    = 2;
  localparam int COMMON_WIDTH     = 7;
  localparam int COMMON_MODE_BIT  = 7;
  localparam int SAMPLE_WIDTH     = 14;

  // ----------------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------------
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [1:0] RESET_IRQ  = 2'h0;

endpackage : ffmt_pkg

// ==== ffmt_compare.sv ====
// Threshold comparison stage with debounce counter for freefall/motion detection.
// Operation
// - Per-axis select clear: all axes use the common 7-bit threshold, 63 mg per count.
// - Per-axis select set: common threshold ignored, each axis uses own register pair.
// - Per-axis threshold is an unsigned 13-bit magnitude, about 63 mg per count.
// - Axis threshold bits 12:6 from high register low seven bits, 5:0 from low register.
// - Logic select 0: low-g only when every enabled axis magnitude is below threshold.
// - Logic select 1: high-g when any enabled axis magnitude exceeds threshold.
// - Per-axis mode uses the same decision logic with individual thresholds.
// - Comparison drives a debounce counter; event flag rises when count limit reached.
`timescale 1ns/1ps

module ffmt_compare
  import ffmt_pkg::*;
#(
  parameter int SAMPLE_W = ffmt_pkg::SAMPLE_WIDTH
)
(
  // Clock and reset
  input  wire logic                 core_clk,
  input  wire logic                 rst,
  // Register port
  input  wire logic [7:0]           reg_addr,
  input  wire logic [7:0]           reg_wdata,
  input  wire logic                 reg_wr,
  input  wire logic                 reg_rd,
  output logic      [7:0]           reg_rdata,
  // Sample input, one axis set per strobe
  input  wire logic                 sample_valid,
  input  wire logic [SAMPLE_W-1:0]  sample_x,
  input  wire logic [SAMPLE_W-1:0]  sample_y,
  input  wire logic [SAMPLE_W-1:0]  sample_z,
  // Results
  output logic                      cond_out,
  output logic                      event_flag,
  output logic                      irq
);

  // ----------------------------------------------------------------------
  // Types and helpers
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE   = 2'b01,
    ST_ACTIVE = 2'b10
  } dbnc_state_t;

  function automatic logic [SAMPLE_W-1:0] magnitude(input logic [SAMPLE_W-1:0] s);
    magnitude = s[SAMPLE_W-1] ? SAMPLE_W'(~s + 1'b1) : s;
  endfunction

  function automatic logic [THS_WIDTH-1:0] axis_ths(input logic [7:0] hi, input logic [7:0] lo);
    axis_ths = {hi[COMMON_WIDTH-1:0], lo[7:LOW_FIELD_LSB]};
  endfunction

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  logic [7:0]  cfg_r;
  logic [7:0]  common_r;
  logic [7:0]  count_r;
  logic [7:0]  thr_hi_r [3];
  logic [7:0]  thr_lo_r [3];
  logic [1:0]  irq_status_r;
  logic [1:0]  irq_enable_r;
  logic [1:0]  irq_clear;
  logic [7:0]  dbnc_r;
  logic [7:0]  dbnc_nxt;
  dbnc_state_t state_r;
  logic        cond_r;
  logic        event_r;
  logic        event_prev_r;

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      cfg_r    <= RESET_BYTE;
      common_r <= RESET_BYTE;
      count_r  <= RESET_BYTE;
      for (int i = 0; i < 3; i++)
      begin
        thr_hi_r[i] <= RESET_BYTE;
        thr_lo_r[i] <= RESET_BYTE;
      end
    end
    else if (reg_wr)
    begin
      case (reg_addr)
        ADDR_CFG:        cfg_r       <= reg_wdata;
        ADDR_COMMON_THS: common_r    <= reg_wdata;
        ADDR_COUNT:      count_r     <= reg_wdata;
        ADDR_X_HIGH:     thr_hi_r[0] <= reg_wdata;
        ADDR_X_LOW:      thr_lo_r[0] <= reg_wdata;
        ADDR_Y_HIGH:     thr_hi_r[1] <= reg_wdata;
        ADDR_Y_LOW:      thr_lo_r[1] <= reg_wdata;
        ADDR_Z_HIGH:     thr_hi_r[2] <= reg_wdata;
        ADDR_Z_LOW:      thr_lo_r[2] <= reg_wdata;
        default:         ;
      endcase
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
      reg_rdata <= RESET_BYTE;
    else if (reg_rd)
    begin
      case (reg_addr)
        ADDR_CFG:        reg_rdata <= cfg_r;
        ADDR_COMMON_THS: reg_rdata <= common_r;
        ADDR_COUNT:      reg_rdata <= count_r;
        ADDR_X_HIGH:     reg_rdata <= thr_hi_r[0];
        ADDR_X_LOW:      reg_rdata <= thr_lo_r[0];
        ADDR_Y_HIGH:     reg_rdata <= thr_hi_r[1];
        ADDR_Y_LOW:      reg_rdata <= thr_lo_r[1];
        ADDR_Z_HIGH:     reg_rdata <= thr_hi_r[2];
        ADDR_Z_LOW:      reg_rdata <= thr_lo_r[2];
        ADDR_IRQ_STATUS: reg_rdata <= {6'h00, irq_status_r};
        ADDR_IRQ_ENABLE: reg_rdata <= {6'h00, irq_enable_r};
        ADDR_RESULT:     reg_rdata <= {dbnc_r[5:0], event_r, cond_r};
        default:         reg_rdata <= RESET_BYTE;
      endcase
    end
    else
      reg_rdata <= RESET_BYTE;
  end

  // ----------------------------------------------------------------------
  // Comparison
  // ----------------------------------------------------------------------
  logic [2:0]              axis_en;
  logic [2:0]              below;
  logic [2:0]              above;
  logic [SAMPLE_W-1:0]     samples [3];
  logic [THS_WIDTH-1:0]    ths_used [3];
  logic                    per_axis;
  logic                    cond_now;

  assign axis_en    = {cfg_r[CFG_ZEN_BIT], cfg_r[CFG_YEN_BIT], cfg_r[CFG_XEN_BIT]};
  assign per_axis   = thr_hi_r[0][HIGH_SEL_BIT];
  assign samples[0] = sample_x;
  assign samples[1] = sample_y;
  assign samples[2] = sample_z;

  for (genvar a = 0; a < 3; a++)
  begin : g_axis
    logic [THS_WIDTH:0] mag;
    assign ths_used[a] = per_axis ? axis_ths(thr_hi_r[a], thr_lo_r[a])
                                  : THS_WIDTH'(common_r[COMMON_WIDTH-1:0]);
    assign mag      = (THS_WIDTH+1)'(magnitude(samples[a]));
    assign below[a] = mag < {1'b0, ths_used[a]};
    assign above[a] = mag > {1'b0, ths_used[a]};
  end

  always_comb
  begin
    if (cfg_r[CFG_OAE_BIT])
      cond_now = |(above & axis_en);
    else
      cond_now = (axis_en != 3'h0) && ((below | ~axis_en) == 3'h7);
  end

  // ----------------------------------------------------------------------
  // Debounce
  // ----------------------------------------------------------------------
  always_comb
  begin
    dbnc_nxt = dbnc_r;
    if (cond_now)
      dbnc_nxt = (dbnc_r < count_r) ? dbnc_r + 8'h01 : count_r;
    else if (common_r[COMMON_MODE_BIT])
      dbnc_nxt = 8'h00;
    else if (dbnc_r != 8'h00)
      dbnc_nxt = dbnc_r - 8'h01;
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      dbnc_r  <= RESET_BYTE;
      cond_r  <= 1'b0;
      event_r <= 1'b0;
      state_r <= ST_IDLE;
    end
    else if (sample_valid)
    begin
      dbnc_r <= dbnc_nxt;
      cond_r <= cond_now;
      case (state_r)
        ST_IDLE:
          if (cond_now && dbnc_nxt >= count_r)
          begin
            event_r <= 1'b1;
            state_r <= ST_ACTIVE;
          end
        ST_ACTIVE:
          if (dbnc_nxt < count_r || !cond_now)
          begin
            event_r <= 1'b0;
            state_r <= ST_IDLE;
          end
        default:
          state_r <= ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Interrupts: bit 0 event raised, bit 1 event dropped
  // ----------------------------------------------------------------------
  logic [1:0] irq_set;

  assign irq_clear = (reg_wr && reg_addr == ADDR_IRQ_CLEAR) ? reg_wdata[1:0] : 2'h0;
  assign irq_set   = {event_prev_r & ~event_r, event_r & ~event_prev_r};

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      irq_status_r <= RESET_IRQ;
      irq_enable_r <= RESET_IRQ;
      event_prev_r <= 1'b0;
      irq          <= 1'b0;
    end
    else
    begin
      event_prev_r <= event_r;
      irq_status_r <= (irq_status_r & ~irq_clear) | irq_set;
      if (reg_wr && reg_addr == ADDR_IRQ_ENABLE)
        irq_enable_r <= reg_wdata[1:0];
      irq <= |(((irq_status_r & ~irq_clear) | irq_set) & irq_enable_r);
    end
  end

  assign cond_out   = cond_r;
  assign event_flag = event_r;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  property p_common_ths;
    @(posedge core_clk) disable iff (rst)
      !per_axis |-> ths_used[0] == {6'h00, common_r[6:0]};
  endproperty
  a_common_ths: assert property (p_common_ths) else $error("Common threshold not used.");

  property p_axis_ths;
    @(posedge core_clk) disable iff (rst)
      per_axis |-> ths_used[2] == {thr_hi_r[2][6:0], thr_lo_r[2][7:2]};
  endproperty
  a_axis_ths: assert property (p_axis_ths) else $error("Per-axis threshold wrong.");

  property p_ths_width;
    @(posedge core_clk) disable iff (rst)
      per_axis |-> ths_used[1][12:6] == thr_hi_r[1][6:0];
  endproperty
  a_ths_width: assert property (p_ths_width) else $error("Threshold high part wrong.");

  property p_split;
    @(posedge core_clk) disable iff (rst)
      per_axis |-> ths_used[0][5:0] == thr_lo_r[0][7:2];
  endproperty
  a_split: assert property (p_split) else $error("Threshold low part wrong.");

  property p_reserved;
    @(posedge core_clk) disable iff (rst)
      $changed(thr_lo_r[0][1:0]) && $stable(thr_lo_r[0][7:2]) && $stable(thr_hi_r[0]) && $stable(common_r)
        |-> $stable(ths_used[0]);
  endproperty
  a_reserved: assert property (p_reserved) else $error("Reserved bits changed threshold.");

  property p_lowg;
    @(posedge core_clk) disable iff (rst)
      sample_valid && !cfg_r[CFG_OAE_BIT] && axis_en[0] && !below[0] |=> !cond_r;
  endproperty
  a_lowg: assert property (p_lowg) else $error("Low-g declared with axis not below.");

  property p_highg;
    @(posedge core_clk) disable iff (rst)
      sample_valid && cfg_r[CFG_OAE_BIT] && axis_en[1] && above[1] |=> cond_r;
  endproperty
  a_highg: assert property (p_highg) else $error("High-g missed.");

  property p_same_logic;
    @(posedge core_clk) disable iff (rst)
      sample_valid && per_axis && cfg_r[CFG_OAE_BIT] && (above & axis_en) == 3'h0 |=> !cond_r;
  endproperty
  a_same_logic: assert property (p_same_logic) else $error("Condition with no enabled axis above.");

  sequence s_limit_hit;
    sample_valid && cond_now && dbnc_nxt >= count_r;
  endsequence

  property p_debounce;
    @(posedge core_clk) disable iff (rst)
      s_limit_hit |=> event_r && dbnc_r <= count_r;
  endproperty
  a_debounce: assert property (p_debounce) else $error("Event flag not raised at limit.");

endmodule // ffmt_compare

// ==== test_ffmt_compare.sv ====
// Self-checking testbench for the freefall/motion threshold comparison block.
`timescale 1ns/1ps

module test_ffmt_compare;
  import ffmt_pkg::*;

  logic        core_clk;
  logic        rst;
  logic [7:0]  reg_addr;
  logic [7:0]  reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [7:0]  reg_rdata;
  logic        sample_valid;
  logic [13:0] sample_x;
  logic [13:0] sample_y;
  logic [13:0] sample_z;
  logic        cond_out;
  logic        event_flag;
  logic        irq;
  int          err_count;
  int          cmp_count;
  logic [7:0]  rd_val;

  ffmt_compare i_ffmt_compare
  (
    .core_clk     (core_clk),
    .rst          (rst),
    .reg_addr     (reg_addr),
    .reg_wdata    (reg_wdata),
    .reg_wr       (reg_wr),
    .reg_rd       (reg_rd),
    .reg_rdata    (reg_rdata),
    .sample_valid (sample_valid),
    .sample_x     (sample_x),
    .sample_y     (sample_y),
    .sample_z     (sample_z),
    .cond_out     (cond_out),
    .event_flag   (event_flag),
    .irq          (irq)
  );

  initial
  begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  // ----------------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      err_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish();
    if (err_count == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge core_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    rd_val = reg_rdata;
  endtask

  // Sends one sample set and lets the results and the interrupt settle.
  task automatic smp(input logic [13:0] x, input logic [13:0] y, input logic [13:0] z);
    @(posedge core_clk);
    sample_valid <= 1'b1;
    sample_x     <= x;
    sample_y     <= y;
    sample_z     <= z;
    @(posedge core_clk);
    sample_valid <= 1'b0;
    repeat (2) @(posedge core_clk);
    #1;
  endtask

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  task automatic t_reset_regs();
    for (int a = 8'h73; a <= 8'h78; a++)
    begin
      rd(8'(a));
      check(16'(rd_val), 16'h0000);
    end
    rd(8'h90);
    check(16'(rd_val), 16'h0000);
  endtask

  task automatic t_common();
    wr(ADDR_CFG, 8'h78);
    wr(ADDR_COMMON_THS, 8'h10);
    smp(14'h0011, 14'h0000, 14'h0000);
    check(16'(cond_out), 16'h0001);
    smp(14'h0000, 14'h0010, 14'h0000);
    check(16'(cond_out), 16'h0000);
    smp(14'h0000, 14'h0000, 14'h3FEF);
    check(16'(cond_out), 16'h0001);
    wr(ADDR_CFG, 8'h70);
    smp(14'h007F, 14'h0000, 14'h0000);
    check(16'(cond_out), 16'h0000);
    wr(ADDR_CFG, 8'h38);
    smp(14'h000F, 14'h3FF1, 14'h000F);
    check(16'(cond_out), 16'h0001);
    smp(14'h000F, 14'h000F, 14'h0010);
    check(16'(cond_out), 16'h0000);
    smp(14'h0010, 14'h000F, 14'h000F);
    check(16'(cond_out), 16'h0000);
  endtask

  task automatic t_per_axis();
    wr(ADDR_COMMON_THS, 8'h01);
    wr(ADDR_X_HIGH, 8'h81);
    wr(ADDR_X_LOW, 8'h0B);
    wr(ADDR_Y_HIGH, 8'h7F);
    wr(ADDR_Y_LOW, 8'hFC);
    wr(ADDR_Z_HIGH, 8'h7F);
    wr(ADDR_Z_LOW, 8'hFC);
    rd(ADDR_X_LOW);
    check(16'(rd_val), 16'h000B);
    wr(ADDR_X_LOW, 8'h08);
    wr(ADDR_CFG, 8'h78);
    smp(14'h0042, 14'h0000, 14'h0000);
    check(16'(cond_out), 16'h0000);
    smp(14'h0043, 14'h0000, 14'h0000);
    check(16'(cond_out), 16'h0001);
    smp(14'h0000, 14'h1FFF, 14'h1FFF);
    check(16'(cond_out), 16'h0000);
    wr(ADDR_X_HIGH, 8'h01);
    smp(14'h0000, 14'h0002, 14'h0000);
    check(16'(cond_out), 16'h0001);
  endtask

  task automatic t_debounce_irq();
    wr(ADDR_COMMON_THS, 8'h90);
    wr(ADDR_COUNT, 8'h03);
    smp(14'h0000, 14'h0000, 14'h0000);
    wr(ADDR_IRQ_CLEAR, 8'h03);
    wr(ADDR_IRQ_ENABLE, 8'h01);
    smp(14'h0020, 14'h0000, 14'h0000);
    check(16'(event_flag), 16'h0000);
    smp(14'h0020, 14'h0000, 14'h0000);
    smp(14'h0020, 14'h0000, 14'h0000);
    check(16'(event_flag), 16'h0001);
    check(16'(irq), 16'h0001);
    smp(14'h0020, 14'h0000, 14'h0000);
    rd(ADDR_RESULT);
    check(16'(rd_val), 16'h000F);
    rd(ADDR_IRQ_STATUS);
    check(16'(rd_val & 8'h01), 16'h0001);
    wr(ADDR_IRQ_CLEAR, 8'h01);
    #1;
    check(16'(irq), 16'h0000);
    wr(ADDR_IRQ_ENABLE, 8'h00);
    smp(14'h0000, 14'h0000, 14'h0000);
    check(16'(event_flag), 16'h0000);
    check(16'(irq), 16'h0000);
    wr(ADDR_IRQ_ENABLE, 8'h02);
    repeat (2) @(posedge core_clk);
    #1;
    check(16'(irq), 16'h0001);
    wr(ADDR_IRQ_CLEAR, 8'h02);
    repeat (2) @(posedge core_clk);
    #1;
    check(16'(irq), 16'h0000);
  endtask

  // ----------------------------------------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------------------------------------
  initial
  begin
    err_count    = 0;
    cmp_count    = 0;
    rst          = 1'b1;
    reg_addr     = 8'h00;
    reg_wdata    = 8'h00;
    reg_wr       = 1'b0;
    reg_rd       = 1'b0;
    sample_valid = 1'b0;
    sample_x     = 14'h0000;
    sample_y     = 14'h0000;
    sample_z     = 14'h0000;
    repeat (20) @(posedge core_clk);
    rst <= 1'b0;
    t_reset_regs();
    t_common();
    t_per_axis();
    t_debounce_irq();
    tally_and_finish();
  end

  initial
  begin
    repeat (100000) @(posedge core_clk);
    err_count++;
    tally_and_finish();
  end

endmodule // test_ffmt_compare
